// file: verilog/isc_core.sv
`timescale 1ns/1ps
`include "isc_defines.svh"
module isc_core
   import isc_pkg::*;
#(
   parameter int STACK_DEPTH = `ISC_STACK_DEPTH
) (
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   output logic     [`ISC_PC_W-1:0]  progAddr,
   input  wire logic [`ISC_IR_W-1:0] progData,
   output logic     [`ISC_DA_W-1:0]  dataAddr,
   input  wire logic [7:0]           dataRd,
   output logic     [7:0]            dataWr,
   output logic                      dataWe,
   output logic     [7:0]            acc,
   output logic                      zeroFlag,
   output logic                      carryFlag,
   output logic                      halfCarryFlag,
   output logic                      signedRangeFlag,
   output logic                      execStrobe,
   output logic                      extraCycle
);
   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   generate
      if (STACK_DEPTH < 2) begin : g_bad
         $error("isc_core: STACK_DEPTH must be at least 2");
      end
   endgenerate

   logic [1:0]           rstSync_r;
   wire                  rst_n = rstSync_r[1];
   logic [1:0]           phase_r, phase_nxt;
   isc_state_e           state_r, state_nxt;
   logic [`ISC_IR_W-1:0] ir_r, ir_nxt;
   logic [`ISC_PC_W-1:0] pc_r, pc_nxt, pAddr_r, pAddr_nxt, stackTop;
   logic [`ISC_DA_W-1:0] dAddr_r, dAddr_nxt;
   logic [7:0]           acc_r, acc_nxt, wr_r, wr_nxt;
   logic                 we_r, we_nxt, done_r, done_nxt;
   logic                 z_r, z_nxt, c_r, c_nxt, ac_r, ac_nxt, ov_r, ov_nxt;
   logic [SP_W-1:0]      sp_r, sp_nxt;
   logic                 pushEn, twoCyc, tableRd, wb, wbMem, setZ;
   logic                 skipTaken;
   logic [7:0]           res, opnd;
   logic [10:0]          t;

   wire [1:0] cls     = ir_r[13:12];
   wire [3:0] fn      = ir_r[11:8];
   wire       toMem   = ir_r[7];
   wire [1:0] bsub    = ir_r[11:10];
   wire [2:0] bidx    = ir_r[9:7];
   wire [6:0] ctl     = ir_r[6:0];
   wire [7:0] bitMask = 8'h01 << bidx;
   wire       execNow = (phase_r == `ISC_PH_LAST) && (state_r == ST_RUN);

   function automatic logic [10:0] aluAdd(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       cin);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      aluAdd = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
   endfunction

   function automatic logic [SP_W-1:0] spStep(input logic [SP_W-1:0] p,
                                              input logic            up);
      if (up) begin
         spStep = (p == SP_W'(STACK_DEPTH - 1)) ? '0 : p + SP_W'(1);
      end else begin
         spStep = (p == '0) ? SP_W'(STACK_DEPTH - 1) : p - SP_W'(1);
      end
   endfunction

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end

   always_comb begin
      phase_nxt = phase_r + 2'h1;
      state_nxt = state_r;
      ir_nxt    = ir_r;
      dAddr_nxt = dAddr_r;
      pc_nxt    = pc_r;
      pAddr_nxt = pAddr_r;
      acc_nxt   = acc_r;
      wr_nxt    = wr_r;
      we_nxt    = 1'b0;
      done_nxt  = 1'b0;
      z_nxt     = z_r;
      c_nxt     = c_r;
      ac_nxt    = ac_r;
      ov_nxt    = ov_r;
      sp_nxt    = sp_r;
      pushEn    = 1'b0;
      twoCyc    = 1'b0;
      tableRd   = 1'b0;
      wb        = 1'b0;
      wbMem     = 1'b0;
      setZ      = 1'b0;
      skipTaken = 1'b0;
      res       = 8'h00;
      t         = 11'h000;
      opnd      = (cls == `ISC_CLS_IMM) ? ir_r[7:0] : dataRd;
      if (phase_r == 2'h0) begin
         ir_nxt    = progData;
         dAddr_nxt = progData[6:0];
      end
      if (phase_r == `ISC_PH_LAST) begin
         case (state_r)
            ST_RUN: begin
               done_nxt = 1'b1;
               pc_nxt   = pc_r + 11'h001;
               if (cls == `ISC_CLS_BR) begin
                  pc_nxt = ir_r[10:0];
                  twoCyc = 1'b1;
                  if (ir_r[11]) begin
                     pushEn = 1'b1;
                     sp_nxt = spStep(sp_r, 1'b1);
                  end
               end else if (cls == `ISC_CLS_BIT) begin
                  if (bsub == `ISC_B_SET) begin
                     res   = dataRd | bitMask;
                     wb    = 1'b1;
                     wbMem = 1'b1;
                  end else if (bsub == `ISC_B_CLR) begin
                     res   = dataRd & ~bitMask;
                     wb    = 1'b1;
                     wbMem = 1'b1;
                  end else begin
                     skipTaken = ((dataRd & bitMask) != 8'h00) ==
                                 (bsub == `ISC_B_SKS);
                  end
               end else if (cls == `ISC_CLS_MEM && fn == `ISC_F_CTL) begin
                  if (toMem) begin
                     skipTaken = (dataRd == 8'h00);
                  end else if (ctl == `ISC_C_RET || ctl == `ISC_C_INTERRUPT_EXIT) begin
                     pc_nxt = stackTop;
                     sp_nxt = spStep(sp_r, 1'b0);
                     twoCyc = 1'b1;
                  end else if (ctl == `ISC_C_TBL) begin
                     tableRd = 1'b1;
                  end
               end else begin
                  wb    = 1'b1;
                  wbMem = (cls == `ISC_CLS_MEM) && toMem;
                  case (fn)
                     `ISC_F_MOV: res = wbMem ? acc_r : opnd;
                     `ISC_F_ADD: t = aluAdd(acc_r, opnd, 1'b0);
                     `ISC_F_ADC: t = aluAdd(acc_r, opnd, c_r);
                     `ISC_F_SUB: t = aluAdd(acc_r, ~opnd, 1'b1);
                     `ISC_F_SBC: t = aluAdd(acc_r, ~opnd, ~c_r);
                     `ISC_F_AND: res = acc_r & opnd;
                     `ISC_F_OR:  res = acc_r | opnd;
                     `ISC_F_XOR: res = acc_r ^ opnd;
                     `ISC_F_CPL: res = ~opnd;
                     `ISC_F_INC: res = opnd + 8'h01;
                     `ISC_F_DEC: res = opnd - 8'h01;
                     `ISC_F_RR:  res = {opnd[0], opnd[7:1]};
                     `ISC_F_RL:  res = {opnd[6:0], opnd[7]};
                     `ISC_F_RRC: begin
                        res   = {c_r, opnd[7:1]};
                        c_nxt = opnd[0];
                     end
                     `ISC_F_RLC: begin
                        res   = {opnd[6:0], c_r};
                        c_nxt = opnd[7];
                     end
                     default: res = opnd;
                  endcase
                  // Carry doubles as the borrow flag on subtraction.
                  if (fn >= `ISC_F_ADD && fn <= `ISC_F_SBC) begin
                     res    = t[7:0];
                     c_nxt  = (fn >= `ISC_F_SUB) ? ~t[8] : t[8];
                     ac_nxt = (fn >= `ISC_F_SUB) ? ~t[9] : t[9];
                     ov_nxt = t[10];
                  end
                  setZ = (fn >= `ISC_F_ADD && fn <= `ISC_F_DEC);
               end
               if (setZ) begin
                  z_nxt = (res == 8'h00);
               end
               if (skipTaken) begin
                  pc_nxt = pc_r + 11'h002;
                  twoCyc = 1'b1;
               end
               if (wb && wbMem) begin
                  if (dAddr_r == `ISC_PCL_ADDR) begin
                     pc_nxt = {pc_r[10:8], res};
                     twoCyc = 1'b1;
                  end else begin
                     we_nxt = 1'b1;
                     wr_nxt = res;
                  end
               end else if (wb) begin
                  acc_nxt = res;
               end
               if (tableRd) begin
                  state_nxt = ST_TABLE;
                  pAddr_nxt = {pc_r[10:8], acc_r};
               end else begin
                  pAddr_nxt = pc_nxt;
                  state_nxt = twoCyc ? ST_REFILL : ST_RUN;
               end
            end
            // The prefetched word is dropped; the cycle refetches the target.
            ST_REFILL: state_nxt = ST_RUN;
            ST_TABLE: begin
               acc_nxt   = ir_r[7:0];
               pAddr_nxt = pc_r;
               state_nxt = ST_RUN;
            end
            default: state_nxt = ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= 2'h0;
         state_r <= ST_RUN;
         ir_r    <= '0;
         dAddr_r <= '0;
         pc_r    <= `ISC_PC_RST;
         pAddr_r <= `ISC_PC_RST;
         acc_r   <= `ISC_ACC_RST;
         wr_r    <= 8'h00;
         we_r    <= 1'b0;
         done_r  <= 1'b0;
         z_r     <= 1'b0;
         c_r     <= 1'b0;
         ac_r    <= 1'b0;
         ov_r    <= 1'b0;
         sp_r    <= '0;
      end else begin
         phase_r <= phase_nxt;
         state_r <= state_nxt;
         ir_r    <= ir_nxt;
         dAddr_r <= dAddr_nxt;
         pc_r    <= pc_nxt;
         pAddr_r <= pAddr_nxt;
         acc_r   <= acc_nxt;
         wr_r    <= wr_nxt;
         we_r    <= we_nxt;
         done_r  <= done_nxt;
         z_r     <= z_nxt;
         c_r     <= c_nxt;
         ac_r    <= ac_nxt;
         ov_r    <= ov_nxt;
         sp_r    <= sp_nxt;
      end
   end

   isc_stack #(
      .DEPTH (STACK_DEPTH),
      .WIDTH (`ISC_PC_W),
      .AW    (SP_W)
   ) u_stack (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wrEn    (pushEn),
      .wrAddr  (sp_r),
      .wrData  (pc_r + 11'h001),
      .rdAddr  (spStep(sp_r, 1'b0)),
      .rdData  (stackTop)
   );

   assign progAddr        = pAddr_r;
   assign dataAddr        = dAddr_r;
   assign dataWr          = wr_r;
   assign dataWe          = we_r;
   assign acc             = acc_r;
   assign zeroFlag        = z_r;
   assign carryFlag       = c_r;
   assign halfCarryFlag   = ac_r;
   assign signedRangeFlag = ov_r;
   assign execStrobe      = done_r;
   assign extraCycle      = (state_r != ST_RUN);

   wire [8:0] sum9   = {1'b0, acc_r} + {1'b0, dataRd};
   wire isMem        = execNow && cls == `ISC_CLS_MEM && !toMem;
   wire isJmp        = execNow && cls == `ISC_CLS_BR && !ir_r[11];
   wire isCall       = execNow && cls == `ISC_CLS_BR && ir_r[11];
   wire isRet        = execNow && cls == `ISC_CLS_MEM && fn == `ISC_F_CTL &&
                       !toMem && ctl == `ISC_C_RET;
   wire isTbl        = execNow && cls == `ISC_CLS_MEM && fn == `ISC_F_CTL &&
                       !toMem && ctl == `ISC_C_TBL;
   wire isBitSkip    = execNow && cls == `ISC_CLS_BIT && bsub[1];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_exec_spacing;
      execStrobe |-> phase_r == 2'h0 ##1 !execStrobe [*3];
   endproperty
   a_exec_spacing: assert property (p_exec_spacing)
      else $error("instruction cycles not four clocks apart");
   property p_jump;
      isJmp |=> (state_r == ST_REFILL && pc_r == $past(ir_r[10:0]) &&
                 sp_r == $past(sp_r)) ##4 (state_r == ST_RUN);
   endproperty
   a_jump: assert property (p_jump)
      else $error("branch target or extra cycle wrong");
   property p_call_push;
      isCall |=> ##1 stackTop == $past(pc_r, 2) + 11'h001;
   endproperty
   a_call_push: assert property (p_call_push)
      else $error("call did not save the following address");
   property p_ret;
      isRet |=> pc_r == $past(stackTop) && state_r == ST_REFILL;
   endproperty
   a_ret: assert property (p_ret)
      else $error("return did not resume at saved address");
   property p_table;
      isTbl |=> state_r == ST_TABLE ##4 state_r == ST_RUN;
   endproperty
   a_table: assert property (p_table)
      else $error("table read not two cycles");
   property p_skip_taken;
      isBitSkip && skipTaken |=> state_r == ST_REFILL &&
                                  pc_r == $past(pc_r) + 11'h002;
   endproperty
   a_skip_taken: assert property (p_skip_taken)
      else $error("taken skip wrong");
   property p_skip_not;
      isBitSkip && !skipTaken |=> state_r == ST_RUN &&
                                   pc_r == $past(pc_r) + 11'h001;
   endproperty
   a_skip_not: assert property (p_skip_not)
      else $error("untaken skip wrong");
   property p_pcl;
      execNow && cls == `ISC_CLS_MEM && toMem && fn == `ISC_F_MOV &&
      dAddr_r == `ISC_PCL_ADDR |=> state_r == ST_REFILL && !dataWe &&
                                   pc_r[7:0] == $past(acc_r);
   endproperty
   a_pcl: assert property (p_pcl)
      else $error("low byte write did not jump");
   property p_add;
      isMem && fn == `ISC_F_ADD |=> carryFlag == $past(sum9[8]) &&
         acc == $past(sum9[7:0]) && zeroFlag == ($past(sum9[7:0]) == 8'h00);
   endproperty
   a_add: assert property (p_add)
      else $error("add result or carry wrong");
   property p_sub;
      execNow && cls == `ISC_CLS_IMM && fn == `ISC_F_SUB |=>
         carryFlag == ($past(acc_r) < $past(ir_r[7:0]));
   endproperty
   a_sub: assert property (p_sub)
      else $error("borrow wrong");
   property p_and_zero;
      isMem && fn == `ISC_F_AND |=> zeroFlag == (acc == 8'h00);
   endproperty
   a_and_zero: assert property (p_and_zero)
      else $error("zero flag wrong after and");
   property p_bitset;
      execNow && cls == `ISC_CLS_BIT && bsub == `ISC_B_SET &&
      dAddr_r != `ISC_PCL_ADDR |=> dataWe &&
         dataWr == ($past(dataRd) | $past(bitMask));
   endproperty
   a_bitset: assert property (p_bitset)
      else $error("bit set touched other bits");
   property p_rrc;
      isMem && fn == `ISC_F_RRC |=> carryFlag == $past(dataRd[0]) &&
                                    acc[7] == $past(carryFlag);
   endproperty
   a_rrc: assert property (p_rrc)
      else $error("rotate through carry wrong");
   property p_rr;
      isMem && fn == `ISC_F_RR |=> acc[7] == $past(dataRd[0]) && $stable(c_r);
   endproperty
   a_rr: assert property (p_rr)
      else $error("plain rotate wrong");
   property p_inc;
      isMem && fn == `ISC_F_INC |=> acc == $past(dataRd) + 8'h01;
   endproperty
   a_inc: assert property (p_inc)
      else $error("increment wrong");
   property p_movi;
      execNow && cls == `ISC_CLS_IMM && fn == `ISC_F_MOV |=>
         acc == $past(ir_r[7:0]);
   endproperty
   a_movi: assert property (p_movi)
      else $error("immediate move wrong");

   c_jump: cover property (isJmp ##1 state_r == ST_REFILL);
   c_call: cover property (isCall ##[4:40] isRet);
   c_skip: cover property (isBitSkip && skipTaken);
   c_tbl:  cover property (isTbl ##1 state_r == ST_TABLE);
endmodule

// file: verilog/isc_defines.svh
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH
// Functional notes
// - One instruction cycle is four consecutive system clock periods.
// - Ordinary instructions take one cycle; branch, call, table read take two.
// - Branch, call, return and interrupt return add one extra cycle.
// - A write to the program counter low byte jumps and adds a cycle.
// - A taken skip adds one cycle; an untaken skip takes one.
// - Skips test a memory byte or one bit and bypass the next instruction.
// - Call saves the following address; return resumes at that address.
// - Branch loads the target without saving a return address.
// - Add reports carry above 255; subtract reports borrow below zero.
// - Increment and decrement change by one, into memory or accumulator.
// - And, or, xor and invert set zero flag when result is zero.
// - Rotates shift one bit; through-carry forms exchange a bit with carry.
// - Moves are memory to accumulator, accumulator to memory, immediate.
// - Two-operand logic always uses the accumulator as one operand.
// - Bit set and clear change only the indexed bit of the byte.
// - Add and subtract update zero, carry, half carry and overflow.
`define ISC_PH_LAST     2'h3
`define ISC_PC_W        11
`define ISC_DA_W        7
`define ISC_IR_W        14
`define ISC_STACK_DEPTH 6
`define ISC_PCL_ADDR    7'h02
`define ISC_PC_RST      11'h000
`define ISC_ACC_RST     8'h00
`define ISC_CLS_MEM     2'h0
`define ISC_CLS_IMM     2'h1
`define ISC_CLS_BIT     2'h2
`define ISC_CLS_BR      2'h3
`define ISC_F_MOV       4'h0
`define ISC_F_ADD       4'h1
`define ISC_F_ADC       4'h2
`define ISC_F_SUB       4'h3
`define ISC_F_SBC       4'h4
`define ISC_F_AND       4'h5
`define ISC_F_OR        4'h6
`define ISC_F_XOR       4'h7
`define ISC_F_CPL       4'h8
`define ISC_F_INC       4'h9
`define ISC_F_DEC       4'ha
`define ISC_F_RR        4'hb
`define ISC_F_RL        4'hc
`define ISC_F_RRC       4'hd
`define ISC_F_RLC       4'he
`define ISC_F_CTL       4'hf
`define ISC_B_SET       2'h0
`define ISC_B_CLR       2'h1
`define ISC_B_SKC       2'h2
`define ISC_B_SKS       2'h3
`define ISC_C_NOP       7'h00
`define ISC_C_RET       7'h01
`define ISC_C_INTERRUPT_EXIT      7'h02
`define ISC_C_TBL       7'h03
`endif

// file: verilog/isc_pkg.sv
package isc_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_REFILL, ST_TABLE} isc_state_e;
endpackage

// file: verilog/isc_stack.sv
`timescale 1ns/1ps
module isc_stack #(
   parameter int DEPTH = 6,
   parameter int WIDTH = 11,
   parameter int AW    = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   generate
      if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_bad
         $error("isc_stack: DEPTH does not fit the address width");
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Read data is registered every clock, so a push shows on the top within two edges.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= '0;
      end else begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// file: verif/instruction_cycle_sequencer_tb_top.sv
`timescale 1ns/1ps
module instruction_cycle_sequencer_tb_top
   import isc_pkg::*;
();
   logic        clk_sys;
   logic        nrst;
   logic [10:0] progAddr;
   logic [13:0] progData;
   logic [6:0]  dataAddr;
   logic [7:0]  dataRd;
   logic [7:0]  dataWr;
   logic        dataWe;
   logic [7:0]  acc;
   logic        zeroFlag;
   logic        carryFlag;
   logic        halfCarryFlag;
   logic        signedRangeFlag;
   logic        execStrobe;
   logic        extraCycle;
   logic [13:0] rom [0:2047];
   logic [7:0]  ram [0:127];
   int          n_fail;
   int          checked;
   int          cyc;
   int          stamps [$];
   logic [10:0] addrs [$];
   logic [7:0]  accs [$];
   logic [3:0]  fls [$];
   logic        exs [$];

   isc_core #(.STACK_DEPTH(6)) dut_u (
      .clk_sys        (clk_sys),
      .nrst           (nrst),
      .progAddr       (progAddr),
      .progData       (progData),
      .dataAddr       (dataAddr),
      .dataRd         (dataRd),
      .dataWr         (dataWr),
      .dataWe         (dataWe),
      .acc            (acc),
      .zeroFlag       (zeroFlag),
      .carryFlag      (carryFlag),
      .halfCarryFlag  (halfCarryFlag),
      .signedRangeFlag(signedRangeFlag),
      .execStrobe     (execStrobe),
      .extraCycle     (extraCycle)
   );

   // Both memories answer combinationally, as the core samples them mid-cycle.
   assign progData = rom[progAddr];
   assign dataRd   = ram[dataAddr];

   always #25 clk_sys = ~clk_sys;

   // Each executed instruction leaves a record of its timing and results.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (dataWe === 1'b1) begin
         ram[dataAddr] <= dataWr;
      end
      if (execStrobe === 1'b1) begin
         stamps.push_back(cyc);
         addrs.push_back(progAddr);
         accs.push_back(acc);
         fls.push_back({zeroFlag, carryFlag, halfCarryFlag, signedRangeFlag});
         exs.push_back(extraCycle);
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d failures=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Memories are cleared once the core is held in reset, so that a write
   // still pending from the last program cannot land after the clear.
   task automatic begin_prog();
      nrst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 2048; i++) begin
         rom[i] = 14'h0000;
      end
      for (int i = 0; i < 128; i++) begin
         ram[i] = 8'h00;
      end
   endtask

   task automatic go(input int n);
      int k;
      int rel;
      repeat (2) @(posedge clk_sys);
      stamps.delete();
      addrs.delete();
      accs.delete();
      fls.delete();
      exs.delete();
      nrst <= 1'b1;
      rel = cyc;
      for (k = 0; k < 600 && stamps.size() < n; k++) begin
         @(posedge clk_sys);
      end
      check(16'(stamps.size()), 16'(n));
      // Release passes two flops, then one full instruction cycle runs.
      if (stamps.size() > 0) begin
         check(16'(stamps[0] - rel), 16'h0007);
      end
   endtask

   // A zero gap skips the spacing test for the first record.
   task automatic step(input int i, input logic [10:0] a, input int dt,
                       input logic [7:0] av, input logic ex, input bit ca = 1);
      check(16'(addrs[i]), 16'(a));
      check(16'(exs[i]), 16'(ex));
      if (dt > 0) check(16'(stamps[i] - stamps[i-1]), 16'(dt));
      if (ca) check(16'(accs[i]), 16'(av));
   endtask

   task automatic t_timing();
      begin_prog();
      rom[0] = 14'h100f;
      rom[1] = 14'h3005;
      rom[2] = 14'h1099;
      rom[5] = 14'h1101;
      rom[6] = 14'h3006;
      go(4);
      step(0, 11'h001, 0, 8'h0f, 1'b0);
      step(1, 11'h005, 4, 8'h0f, 1'b1);
      step(2, 11'h006, 8, 8'h10, 1'b0);
      step(3, 11'h006, 4, 8'h10, 1'b1);
   endtask

   // A branch inside the subroutine must not disturb the saved return.
   task automatic t_call();
      for (int r = 1; r < 3; r++) begin
         begin_prog();
         rom[0] = 14'h3808;
         rom[1] = 14'h105a;
         rom[2] = 14'h3002;
         rom[8] = 14'h300a;
         rom[10] = 14'h0f00 | 14'(r);
         go(5);
         step(0, 11'h008, 0, 8'h00, 1'b1);
         step(1, 11'h00a, 8, 8'h00, 1'b1);
         step(2, 11'h001, 8, 8'h00, 1'b1);
         step(3, 11'h002, 8, 8'h5a, 1'b0);
         step(4, 11'h002, 4, 8'h5a, 1'b1);
      end
   endtask

   task automatic t_pcl();
      begin_prog();
      rom[0] = 14'h1007;
      rom[1] = 14'h0082;
      rom[2] = 14'h1099;
      rom[7] = 14'h0120;
      rom[8] = 14'h0521;
      rom[9] = 14'h3009;
      ram[32] = 8'hfd;
      ram[33] = 8'h0b;
      go(4);
      step(0, 11'h001, 0, 8'h07, 1'b0);
      step(1, 11'h007, 4, 8'h07, 1'b1);
      step(2, 11'h008, 8, 8'h04, 1'b0);
      step(3, 11'h009, 4, 8'h00, 1'b0);
      check(16'(fls[2]), 16'h0006);
      check(16'(fls[3]), 16'h000e);
      check(16'(ram[2]), 16'h0000);
   endtask

   // Even entries skip, odd entries fall through.
   task automatic t_skip();
      logic [13:0] op [6] = '{14'h0f90, 14'h0f90, 14'h2990, 14'h2990,
                              14'h2d90, 14'h2d90};
      logic [7:0]  mv [6] = '{8'h00, 8'h01, 8'h00, 8'h08, 8'h08, 8'h00};
      for (int c = 0; c < 6; c++) begin
         begin_prog();
         ram[16] = mv[c];
         rom[0] = op[c];
         rom[1] = 14'h1011;
         rom[2] = 14'h1022;
         rom[3] = 14'h3003;
         go(2);
         if (c % 2 == 0) begin
            step(0, 11'h002, 0, 8'h00, 1'b1);
            step(1, 11'h003, 8, 8'h22, 1'b0);
         end else begin
            step(0, 11'h001, 0, 8'h00, 1'b0);
            step(1, 11'h002, 4, 8'h11, 1'b0);
         end
      end
   endtask

   // Flag order in the record is zero, carry, half carry, signed range.
   task automatic t_arith();
      logic [13:0] p [10] = '{14'h10ff, 14'h1101, 14'h1301, 14'h1500,
         14'h1680, 14'h1780, 14'h1200, 14'h1401, 14'h107f, 14'h1101};
      logic [7:0]  ea [10] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h80, 8'h00,
         8'h01, 8'h00, 8'h7f, 8'h80};
      logic [3:0]  ef [10] = '{4'h0, 4'he, 4'h6, 4'he, 4'h6, 4'he, 4'h0,
         4'h8, 4'h8, 4'h3};
      begin_prog();
      for (int i = 0; i < 10; i++) begin
         rom[i] = p[i];
      end
      rom[10] = 14'h300a;
      go(11);
      for (int i = 0; i < 10; i++) begin
         step(i, 11'(i + 1), i ? 4 : 0, ea[i], 1'b0);
         check(16'(fls[i]), 16'(ef[i]));
      end
   endtask

   task automatic t_mem();
      logic [13:0] p [12] = '{14'h0b20, 14'h0d20, 14'h0e20, 14'h0c20,
         14'h0920, 14'h0aa0, 14'h2120, 14'h27a0, 14'h0820, 14'h0020,
         14'h00a1, 14'h0f03};
      logic [7:0]  ea [12] = '{8'hc0, 8'h40, 8'h03, 8'h03, 8'h82, 8'h82,
         8'h82, 8'h82, 8'hfb, 8'h04, 8'h04, 8'h00};
      begin_prog();
      for (int i = 0; i < 12; i++) begin
         rom[i] = p[i];
      end
      rom[12] = 14'h300c;
      ram[32] = 8'h81;
      go(13);
      for (int i = 0; i < 11; i++) begin
         step(i, 11'(i + 1), i ? 4 : 0, ea[i], 1'b0);
      end
      // The table cycle fetches from the accumulator's address in this page.
      step(11, 11'h004, 4, 8'h04, 1'b1);
      step(12, 11'h00c, 8, 8'h20, 1'b1);
      check(16'(fls[0][2]), 16'h0000);
      check(16'(fls[1][2]), 16'h0001);
      check(16'(fls[3][2]), 16'h0001);
      check(16'(ram[32]), 16'h0004);
      check(16'(ram[33]), 16'h0004);
   endtask

   // The whole run needs well under a thousand cycles; this is generous.
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      complete_run();
   end

   initial begin
      clk_sys = 1'b0;
      nrst = 1'b0;
      cyc = 0;
      n_fail = 0;
      checked = 0;
      t_timing();
      t_call();
      t_pcl();
      t_skip();
      t_arith();
      t_mem();
      complete_run();
   end
endmodule
